/* File: hdl/sscm_pkg.sv */
// shared constants and types of the serial switch matrix control block
package sscm_pkg;
	// input spike suppression, rounded up to whole reference cycles
	localparam int          REF_PERIOD_NS = 5;
	localparam int          FILT_NS       = 50;
	localparam int          FILT_CYC      = (FILT_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam logic [3:0]  FILT_CNT      = 4'(FILT_CYC);
	// fastest serial clock the far master may use, kbit/s
	localparam int          SCL_MAX_KBPS  = 400;
	// fixed upper five address bits per variant
	localparam logic [4:0]  ADDR_PFX_OCT  = 5'h13;
	localparam logic [4:0]  ADDR_PFX_DUAL = 5'h11;
	// bit counts within a byte
	localparam logic [3:0]  BYTE_BITS     = 4'h8;
	localparam logic [3:0]  LAST_TX_BIT   = 4'h7;
	// pin synchroniser lanes
	localparam int          PIN_CLR       = 2;
	localparam int          PIN_ADDR_BIT1 = 1;
	localparam int          PIN_ADDR_LSB  = 0;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_ADDR  = 7'h02,
		ST_ACK_A = 7'h04,
		ST_WRITE = 7'h08,
		ST_ACK_W = 7'h10,
		ST_READ  = 7'h20,
		ST_RACK  = 7'h40
	} sscm_state_t;

	typedef struct packed {
		sscm_state_t state;
		logic [3:0]  cnt;
		logic [7:0]  shreg;
		logic [7:0]  tx;
		logic [7:0]  ctrl;
		logic        oe;
		logic        nack;
		logic        scl_d;
		logic        sda_d;
		logic [2:0]  pin_s1;
		logic [2:0]  pin_s2;
	} sscm_core_t;

	localparam sscm_core_t CORE_RST = '{
		state:  ST_IDLE,
		cnt:    4'h0,
		shreg:  8'h00,
		tx:     8'h00,
		ctrl:   8'h00,
		oe:     1'b0,
		nack:   1'b1,
		scl_d:  1'b1,
		sda_d:  1'b1,
		pin_s1: 3'h0,
		pin_s2: 3'h0
	};

	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       out;
		logic [3:0] cnt;
	} sscm_filt_t;

	localparam sscm_filt_t FILT_RST = '{
		sync1: 1'b1,
		sync2: 1'b1,
		out:   1'b1,
		cnt:   4'h0
	};
endpackage

/* File: hdl/sscm_line_if.sv */
// one serial bus line, raw pin level and its filtered copy
`timescale 1ns/1ps
interface sscm_line_if;
	logic raw;
	logic clean;

	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface // sscm_line_if

/* File: hdl/sscm_filter.sv */
// synchroniser and spike filter for one serial bus line
`timescale 1ns/1ps
module sscm_filter (
	input  wire logic       clk,
	input  wire logic       arst_n,
	sscm_line_if.filt       line
);
	sscm_pkg::sscm_filt_t r_reg;
	sscm_pkg::sscm_filt_t r_next;

	// follow the line only after it held a new level long enough
	always_comb
	begin
		r_next       = r_reg;
		r_next.sync1 = line.raw;
		r_next.sync2 = r_reg.sync1;
		if (r_reg.sync2 == r_reg.out)
		begin
			r_next.cnt = 4'h0;
		end
		else if (r_reg.cnt == sscm_pkg::FILT_CNT - 4'h1)
		begin
			r_next.out = r_reg.sync2;
			r_next.cnt = 4'h0;
		end
		else
		begin
			r_next.cnt = r_reg.cnt + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			r_reg <= sscm_pkg::FILT_RST;
		else
			r_reg <= r_next;
	end

	assign line.clean = r_reg.out;

	// a level change only after the full hold count
	chk_filt_hold_count: assert property (@(posedge clk) disable iff (!arst_n)
		$changed(r_reg.out) |-> $past(r_reg.cnt) == sscm_pkg::FILT_CNT - 4'h1)
		else $error("filtered line moved before hold time");

	// a short spike never reaches the output
	chk_filt_spike: assert property (@(posedge clk) disable iff (!arst_n)
		(r_reg.sync2 != r_reg.out) ##1 (r_reg.sync2 == r_reg.out) |=> $stable(r_reg.out))
		else $error("spike passed the filter");
endmodule // sscm_filter

/* File: hdl/sscm_top.sv */
// two-wire slave that sets eight analog switch controls from one byte
`timescale 1ns/1ps
module sscm_top #(
	parameter bit DUAL_VARIANT = 1'b0
) (
	input  wire logic       REF_CLK,
	input  wire logic       ARST_N,
	input  wire logic       SCL,
	input  wire logic       SDA_IN,
	output logic            SDA_OUT,
	output logic            SDA_OE,
	input  wire logic       ADDR_PIN_LSB,
	input  wire logic       ADDR_PIN_BIT1,
	input  wire logic       CLEAR_N,
	output logic [7:0]      SWITCH_ON
);
	sscm_pkg::sscm_core_t r_reg;
	sscm_pkg::sscm_core_t r_next;
	logic                 scl_c;
	logic                 sda_c;
	logic                 scl_rise;
	logic                 scl_fall;
	logic                 start_cond;
	logic                 stop_cond;
	logic                 clr;
	logic                 addr_match;
	logic [6:0]           own_addr;
	logic                 commit;

	sscm_line_if scl_if ();
	sscm_line_if sda_if ();

	// both bus lines pass the same synchroniser and spike filter
	assign scl_if.raw = SCL;
	assign sda_if.raw = SDA_IN;

	sscm_filter u_scl_filt (
		.clk    (REF_CLK),
		.arst_n (ARST_N),
		.line   (scl_if.filt)
	);

	sscm_filter u_sda_filt (
		.clk    (REF_CLK),
		.arst_n (ARST_N),
		.line   (sda_if.filt)
	);

	assign scl_c = scl_if.clean;
	assign sda_c = sda_if.clean;

	// bus events from filtered levels and their previous samples
	assign scl_rise   = scl_c & ~r_reg.scl_d;
	assign scl_fall   = ~scl_c & r_reg.scl_d;
	assign start_cond = scl_c & r_reg.scl_d & r_reg.sda_d & ~sda_c;
	assign stop_cond  = scl_c & r_reg.scl_d & ~r_reg.sda_d & sda_c;

	// address pins and clear come from the board, read only after two flops
	assign clr      = ~r_reg.pin_s2[sscm_pkg::PIN_CLR];
	assign own_addr = {DUAL_VARIANT ? sscm_pkg::ADDR_PFX_DUAL : sscm_pkg::ADDR_PFX_OCT,
		r_reg.pin_s2[sscm_pkg::PIN_ADDR_BIT1],
		r_reg.pin_s2[sscm_pkg::PIN_ADDR_LSB]};
	assign addr_match = (r_reg.shreg[7:1] == own_addr);
	assign commit     = (r_reg.state == sscm_pkg::ST_WRITE) && scl_fall
		&& (r_reg.cnt == sscm_pkg::BYTE_BITS);

	// one bit enters at the low end, so the msb arrives first
	function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
		return {v[6:0], b};
	endfunction

	// protocol engine; stop and start take precedence in any state
	always_comb
	begin
		r_next        = r_reg;
		r_next.pin_s1 = {CLEAR_N, ADDR_PIN_BIT1, ADDR_PIN_LSB};
		r_next.pin_s2 = r_reg.pin_s1;
		r_next.scl_d  = scl_c;
		r_next.sda_d  = sda_c;
		if (stop_cond)
		begin
			r_next.state = sscm_pkg::ST_IDLE;
			r_next.oe    = 1'b0;
		end
		else if (start_cond)
		begin
			// repeated start also lands here
			r_next.state = sscm_pkg::ST_ADDR;
			r_next.cnt   = 4'h0;
			r_next.oe    = 1'b0;
		end
		else
		begin
			case (r_reg.state)
				sscm_pkg::ST_IDLE:
				begin
					r_next.oe = 1'b0;
				end
				sscm_pkg::ST_ADDR:
				begin
					if (scl_rise)
					begin
						r_next.shreg = shift_in(r_reg.shreg, sda_c);
						r_next.cnt   = r_reg.cnt + 4'h1;
					end
					else if (scl_fall && r_reg.cnt == sscm_pkg::BYTE_BITS)
					begin
						// other addresses leave the line alone until next start
						r_next.state = addr_match ? sscm_pkg::ST_ACK_A : sscm_pkg::ST_IDLE;
						r_next.oe    = addr_match;
					end
				end
				sscm_pkg::ST_ACK_A:
				begin
					if (scl_fall)
					begin
						r_next.cnt = 4'h0;
						if (r_reg.shreg[0])
						begin
							r_next.state = sscm_pkg::ST_READ;
							r_next.tx    = r_reg.ctrl;
							r_next.oe    = ~r_reg.ctrl[7];
						end
						else
						begin
							r_next.state = sscm_pkg::ST_WRITE;
							r_next.oe    = 1'b0;
						end
					end
				end
				sscm_pkg::ST_WRITE:
				begin
					if (scl_rise)
					begin
						r_next.shreg = shift_in(r_reg.shreg, sda_c);
						r_next.cnt   = r_reg.cnt + 4'h1;
					end
					else if (commit)
					begin
						r_next.ctrl  = r_reg.shreg;
						r_next.state = sscm_pkg::ST_ACK_W;
						r_next.oe    = 1'b1;
					end
				end
				sscm_pkg::ST_ACK_W:
				begin
					if (scl_fall)
					begin
						r_next.state = sscm_pkg::ST_WRITE;
						r_next.cnt   = 4'h0;
						r_next.oe    = 1'b0;
					end
				end
				sscm_pkg::ST_READ:
				begin
					if (scl_fall)
					begin
						if (r_reg.cnt == sscm_pkg::LAST_TX_BIT)
						begin
							// release for the master's acknowledge
							r_next.state = sscm_pkg::ST_RACK;
							r_next.oe    = 1'b0;
						end
						else
						begin
							r_next.tx  = shift_in(r_reg.tx, 1'b0);
							r_next.oe  = ~r_reg.tx[6];
							r_next.cnt = r_reg.cnt + 4'h1;
						end
					end
				end
				sscm_pkg::ST_RACK:
				begin
					if (scl_rise)
					begin
						r_next.nack = sda_c;
					end
					else if (scl_fall)
					begin
						// an acknowledge asks for the byte once more
						r_next.state = r_reg.nack ? sscm_pkg::ST_IDLE : sscm_pkg::ST_READ;
						r_next.tx    = r_reg.ctrl;
						r_next.oe    = ~r_reg.nack & ~r_reg.ctrl[7];
						r_next.cnt   = 4'h0;
					end
				end
				default:
				begin
					r_next.state = sscm_pkg::ST_IDLE;
					r_next.oe    = 1'b0;
				end
			endcase
		end
		// clear wins over a byte landing in the same cycle
		if (clr)
		begin
			r_next.ctrl = 8'h00;
		end
	end

	// power-up leaves the switch byte at zero
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			r_reg <= sscm_pkg::CORE_RST;
		else
			r_reg <= r_next;
	end

	// open-drain: level is always low, only the enable moves
	assign SDA_OUT   = 1'b0;
	assign SDA_OE    = r_reg.oe;
	assign SWITCH_ON = r_reg.ctrl;

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!ARST_N);

	sequence s_byte_taken;
		(r_reg.state == sscm_pkg::ST_WRITE) && scl_fall && (r_reg.cnt == sscm_pkg::BYTE_BITS);
	endsequence

	sequence s_ack_driven;
		(r_reg.state == sscm_pkg::ST_ACK_W) && r_reg.oe;
	endsequence

	chk_clear_opens: assert property (clr |=> SWITCH_ON == 8'h00)
		else $error("clear did not open all switches");

	chk_addr_match: assert property (
		$rose(r_reg.state == sscm_pkg::ST_ACK_A) |-> $past(addr_match) && SDA_OE)
		else $error("acknowledged a foreign address");

	chk_addr_pins: assert property (
		(r_reg.state == sscm_pkg::ST_ACK_A) |-> r_reg.shreg[2:1] == own_addr[1:0])
		else $error("address pins not honoured");

	chk_prefix_fixed: assert property (
		(r_reg.state == sscm_pkg::ST_ACK_A) |-> r_reg.shreg[7:3]
		== (DUAL_VARIANT ? sscm_pkg::ADDR_PFX_DUAL : sscm_pkg::ADDR_PFX_OCT))
		else $error("address prefix mismatch");

	chk_write_update: assert property (
		(s_byte_taken and !clr) |=> s_ack_driven and (SWITCH_ON == $past(r_reg.shreg)))
		else $error("written byte did not reach the switches");

	chk_ctrl_cause: assert property (
		$changed(r_reg.ctrl) |-> $past(commit) || $past(clr))
		else $error("switch byte changed without a write");

	chk_read_first_bit: assert property (
		$rose(r_reg.state == sscm_pkg::ST_READ)
		|-> SDA_OE == ~$past(r_reg.ctrl[7]) && r_reg.tx == $past(r_reg.ctrl))
		else $error("readback not the applied byte");

	chk_read_release: assert property (
		(r_reg.state == sscm_pkg::ST_READ && scl_fall && r_reg.cnt == sscm_pkg::LAST_TX_BIT)
		|=> !SDA_OE && r_reg.state == sscm_pkg::ST_RACK)
		else $error("line not released after eight read bits");

	chk_idle_quiet: assert property (
		(r_reg.state == sscm_pkg::ST_IDLE) |-> !SDA_OE && SDA_OUT == 1'b0)
		else $error("data line pulled while idle");
endmodule // sscm_top

/* File: verif/sscm_master.sv */
// two-wire bus master model that faces the switch block
`timescale 1ns/1ps
module sscm_master (
	input  wire logic lclk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_pull
);
	// 10 low + 6 high ticks of 160 ns: 390 kbit/s, low phase above 1.3 us
	localparam int T_LOW  = 10;
	localparam int T_HIGH = 6;

	// bus idles: clock driven high, data released to the pull-up
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic ticks(input int n);
		repeat (n) @(posedge lclk);
	endtask

	// data moves mid low phase, sampled late in the high phase
	task automatic bit_io(input logic b, input logic glitch, output logic got);
		scl = 1'b0;
		ticks(T_LOW / 2);
		sda_pull = ~b;
		ticks(2);
		scl = glitch;
		#40 scl = 1'b0; // spike under 50 ns, must not count as a clock
		ticks(T_LOW / 2 - 2);
		scl = 1'b1;
		ticks(T_HIGH);
		got = sda;
	endtask

	// data falls while the clock is high
	task automatic start();
		sda_pull = 1'b0;
		scl = 1'b1;
		ticks(4);
		sda_pull = 1'b1;
		ticks(4);
	endtask

	// data rises while the clock is high, then the bus rests
	task automatic stop();
		scl = 1'b0;
		ticks(T_LOW / 2);
		sda_pull = 1'b1;
		ticks(T_LOW / 2);
		scl = 1'b1;
		ticks(4);
		sda_pull = 1'b0;
		ticks(8);
	endtask

	// msb first, then the slave's acknowledge slot
	task automatic put_byte(input logic [7:0] d, input logic glitch, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], glitch && i == 3, g);
		bit_io(1'b1, 1'b0, g);
		ack = ~g;
	endtask

	// line released for eight bits, then our own ack or nack
	task automatic get_byte(input logic nack, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, 1'b0, g);
			d[i] = g;
		end
		bit_io(nack, 1'b0, g);
	endtask
endmodule // sscm_master

/* File: verif/sscm_top_test.sv */
// self-checking bench of the serial switch block
`timescale 1ns/1ps
module sscm_top_test;
	logic       ref_clk;
	logic       lclk;
	logic       arst_n;
	logic       clear_n;
	logic       pin_lsb;
	logic       pin_bit1;
	logic       scl;
	logic       pull;
	logic       sda_oe;
	logic       sda_out;
	logic [7:0] switch_on;
	wire logic  sda_line;
	int         error_cnt = 0;
	int         tests_run = 0;

	// open-drain data line with pull-up
	assign sda_line = ~(sda_oe | pull);

	sscm_top i_dut (
		.REF_CLK      (ref_clk),
		.ARST_N       (arst_n),
		.SCL          (scl),
		.SDA_IN       (sda_line),
		.SDA_OUT      (sda_out),
		.SDA_OE       (sda_oe),
		.ADDR_PIN_LSB (pin_lsb),
		.ADDR_PIN_BIT1(pin_bit1),
		.CLEAR_N      (clear_n),
		.SWITCH_ON    (switch_on)
	);

	sscm_master i_mst (
		.lclk    (lclk),
		.sda     (sda_line),
		.scl     (scl),
		.sda_pull(pull)
	);

	// reference clock and an unrelated 160 ns link clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial
	begin
		lclk = 1'b0;
		#37;
		forever #80 lclk = ~lclk;
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		if (error_cnt == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// straps and clear change just after a reference edge
	task automatic set_in(input logic clr_in, input logic lsb, input logic bit1);
		@(posedge ref_clk);
		#1;
		clear_n = clr_in;
		pin_lsb = lsb;
		pin_bit1 = bit1;
		repeat (4) @(posedge ref_clk);
	endtask

	// one write transfer; a refused address sends no data
	task automatic wr(input logic [6:0] adr, input logic [7:0] d, input logic glitch,
		input logic ok, input logic [7:0] exp);
		logic a;
		i_mst.start();
		i_mst.put_byte({adr, 1'b0}, 1'b0, a);
		check("addr ack", a, ok);
		if (ok)
			i_mst.put_byte(d, glitch, a);
		i_mst.stop();
		check("switches", switch_on, exp);
	endtask

	task automatic test_power_up();
		check("switches after reset", switch_on, 8'h00);
		check("data out level", sda_out, 1'b0);
	endtask

	task automatic test_write_repeat();
		logic a;
		i_mst.start();
		i_mst.put_byte({7'h4d, 1'b0}, 1'b0, a);
		check("addr ack", a, 1'b1);
		i_mst.put_byte(8'ha5, 1'b0, a);
		check("first byte", switch_on, 8'ha5);
		i_mst.put_byte(8'h3c, 1'b0, a);
		check("second ack", a, 1'b1);
		check("second byte", switch_on, 8'h3c);
		i_mst.stop();
	endtask

	// swapped straps, other variant prefix, wrong low bit
	task automatic test_bad_addr();
		wr(7'h4e, 8'hff, 1'b0, 1'b0, 8'h3c);
		wr(7'h45, 8'hff, 1'b0, 1'b0, 8'h3c);
		wr(7'h4c, 8'hff, 1'b0, 1'b0, 8'h3c);
	endtask

	task automatic test_pins();
		set_in(1'b1, 1'b0, 1'b1);
		wr(7'h4e, 8'h81, 1'b0, 1'b1, 8'h81);
	endtask

	task automatic test_read();
		logic       a;
		logic [7:0] d;
		i_mst.start();
		i_mst.put_byte({7'h4e, 1'b1}, 1'b0, a);
		check("read addr ack", a, 1'b1);
		i_mst.get_byte(1'b0, d);
		check("read byte", d, 8'h81);
		i_mst.get_byte(1'b1, d);
		check("repeat read byte", d, 8'h81);
		check("released after byte", sda_oe, 1'b0);
		check("data out level", sda_out, 1'b0);
		i_mst.stop();
	endtask

	task automatic test_spike();
		wr(7'h4e, 8'h96, 1'b1, 1'b1, 8'h96);
	endtask

	task automatic test_clear();
		set_in(1'b0, 1'b0, 1'b1);
		check("cleared", switch_on, 8'h00);
		set_in(1'b1, 1'b0, 1'b1);
		check("clear released", switch_on, 8'h00);
	endtask

	// main sequence
	initial
	begin
		arst_n = 1'b0;
		clear_n = 1'b1;
		pin_lsb = 1'b1;
		pin_bit1 = 1'b0;
		repeat (12) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		repeat (20) @(posedge ref_clk);
		test_power_up();
		test_write_repeat();
		test_bad_addr();
		test_pins();
		test_read();
		test_spike();
		test_clear();
		report_and_stop();
	end

	// about 13 bytes of bus traffic fit well inside this span
	initial
	begin
		#500000;
		error_cnt++;
		report_and_stop();
	end
endmodule // sscm_top_test
